// file: hdl/tmr_pkg.sv
// package: register map, field positions and counts of the timer block
`default_nettype none
package tmr_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] A_T01_CONTROL = 8'h88;
	localparam logic [7:0] A_T01_MODE    = 8'h89;
	localparam logic [7:0] A_T0_LOW      = 8'h8a;
	localparam logic [7:0] A_T1_LOW      = 8'h8b;
	localparam logic [7:0] A_T0_HIGH     = 8'h8c;
	localparam logic [7:0] A_T1_HIGH     = 8'h8d;
	localparam logic [7:0] A_OPTION      = 8'h94;
	localparam logic [7:0] A_INT_FLAGS   = 8'h95;
	localparam logic [7:0] A_P3_HI_MODE  = 8'ha5;
	localparam logic [7:0] A_PIN_OUT_SEL = 8'ha6;
	localparam logic [7:0] A_T2_CONTROL  = 8'hc8;
	localparam logic [7:0] A_T2_RLD_LOW  = 8'hca;
	localparam logic [7:0] A_T2_RLD_HIGH = 8'hcb;
	localparam logic [7:0] A_T2_LOW      = 8'hcc;
	localparam logic [7:0] A_T2_HIGH     = 8'hcd;
	localparam logic [7:0] A_AUXILIARY_CONTROL_1        = 8'hf8;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int B_T1_OVF   = 7;
	localparam int B_T1_RUN   = 6;
	localparam int B_T0_OVF   = 5;
	localparam int B_T0_RUN   = 4;
	localparam int B_T1_GATE  = 7;
	localparam int B_T1_CT    = 6;
	localparam int B_T1_MODE  = 4;
	localparam int B_T0_GATE  = 3;
	localparam int B_T0_CT    = 2;
	localparam int B_T0_MODE  = 0;
	localparam int B_T2_OVF   = 7;
	localparam int B_T2_EXT   = 6;
	localparam int B_RX_SEL   = 5;
	localparam int B_TX_SEL   = 4;
	localparam int B_T2_EXEN  = 3;
	localparam int B_T2_RUN   = 2;
	localparam int B_T2_CT    = 1;
	localparam int B_T2_CAP   = 0;
	localparam int B_TICK_CLR = 6;
	localparam int B_T2_SRC   = 2;
	localparam int B_T1_SRC   = 1;
	localparam int B_T0_BUZ   = 7;
	localparam int B_T2_BUZ   = 2;
	localparam int B_TICK_FLG = 0;
	localparam int B_TICK_RT  = 0;

	// ------------------------------------------------------------
	// modes, reset values and counts
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_13BIT  = 2'h0;
	localparam logic [1:0] MODE_16BIT  = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT  = 2'h3;
	localparam logic [7:0] RST8        = 8'h00;
	localparam logic [15:0] RST16      = 16'h0000;
	// 2 system clocks per count unit
	localparam logic       UNIT_LAST   = 1'h1;
	// slow clock divided by 16
	localparam logic [3:0] SLOW_LAST   = 4'hf;
	// buzzer 0 period is 64 overflows, so toggle every 32
	localparam logic [4:0] BUZ0_LAST   = 5'h1f;
	localparam logic [15:0] T2_TOP     = 16'hffff;
	// tick intervals 32768, 16384, 8192 and 128, as last count
	localparam logic [14:0] TICK_LAST0 = 15'h7fff;
	localparam logic [14:0] TICK_LAST1 = 15'h3fff;
	localparam logic [14:0] TICK_LAST2 = 15'h1fff;
	localparam logic [14:0] TICK_LAST3 = 15'h007f;

endpackage
`default_nettype wire

// file: hdl/tmr_timers.sv
// timers 0/1/2, buzzer outputs and slow-clock tick counter
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - in timer mode timers 0, 1, 2 advance once every 2 clocks
// - timer 1 counter source: count pin, or slow clock over 16
// - timer 2 counter source: count pin, or slow clock over 16
// - timer 0 buzzer pin gives overflow rate over 64 when enabled
// - timer 2 buzzer pin gives overflow rate over 2 when enabled
// - buzzer frequencies follow the timers' overflow rates
// - timers 0, 1 hold low and high bytes, control and mode registers
// - timer 2 count and reload bytes are all readable and writable
// - trigger falling edge causing capture or reload sets event flag
// - reload mode reloads on overflow and on enabled trigger edge
// - select bits route timer 1 or timer 2 overflow to serial clocks
// - any baud select forces timer 2 into overflow auto-reload
// - tick counter runs on the slow clock
// - rate field picks 32768, 16384, 8192 or 128 slow cycles
// - tick flag sets at interval, clears on entering its service
// - flag register: write 0 clears a flag, write 1 keeps it
// - clear bit resets tick counter and drops back next cycle
module tmr_timers (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// pins
	input  wire logic       timer0_count_pin,
	input  wire logic       timer1_count_pin,
	input  wire logic       timer2_count_pin,
	input  wire logic       timer2_trigger_pin,
	input  wire logic       ext_irq0_pin,
	input  wire logic       ext_irq1_pin,
	input  wire logic       slow_clock_source,
	// service entry strobes
	input  wire logic       timer0_isr_ack,
	input  wire logic       timer1_isr_ack,
	input  wire logic       tick_isr_ack,
	// flags
	output logic            timer0_overflow_flag,
	output logic            timer1_overflow_flag,
	output logic            timer2_overflow_flag,
	output logic            timer2_ext_event_flag,
	output logic            tick_flag,
	// buzzer pins and serial clocks
	output logic            timer0_buzzer_out,
	output logic            timer0_buzzer_oe,
	output logic            timer2_buzzer_out,
	output logic            timer2_buzzer_oe,
	output logic            uart_rx_baud_tick,
	output logic            uart_tx_baud_tick
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0]  timer01_mode;
	logic [7:0]  t0l;
	logic [7:0]  t0h;
	logic [7:0]  t1l;
	logic [7:0]  t1h;
	logic        timer0_run;
	logic        timer1_run;
	logic [15:0] t2cnt;
	logic [15:0] t2rcap;
	logic        uart_rx_clock_select;
	logic        uart_tx_clock_select;
	logic        timer2_ext_enable;
	logic        timer2_run;
	logic        timer2_counter_select;
	logic        timer2_capture_select;
	logic [1:0]  tick_rate_select;
	logic        tick_counter_clear;
	logic        timer1_source_select;
	logic        timer2_source_select;
	logic        timer0_buzzer_enable;
	logic        timer2_buzzer_enable;
	logic        unit_cnt;
	logic [3:0]  pin_q;
	logic        slow_q;
	logic [3:0]  slow_div;
	logic [14:0] tick_cnt;
	logic [4:0]  buz0_cnt;
	logic        wave0;
	logic        wave2;

	// ------------------------------------------------------------
	// timer 0/1 step: returns {overflow, high, low}
	// ------------------------------------------------------------
	function automatic logic [16:0] t01_step(
		input logic [1:0] m,
		input logic [7:0] lo,
		input logic [7:0] hi,
		input logic       inc
	);
		logic [5:0] l6;
		logic [8:0] l9;
		logic [8:0] h9;
		l6 = {1'h0, lo[4:0]} + 6'h01;
		l9 = {1'h0, lo} + 9'h001;
		h9 = {1'h0, hi} + {8'h00, l6[5]};
		t01_step = {1'h0, hi, lo};
		if (inc)
		begin
			unique case (m)
				// low five bits prescale the high byte
				tmr_pkg::MODE_13BIT:
					t01_step = {h9[8], h9[7:0], lo[7:5], l6[4:0]};
				tmr_pkg::MODE_16BIT:
					t01_step = {1'h0, hi, lo} + 17'h0_0001;
				// low byte reloads from high byte
				tmr_pkg::MODE_RELOAD:
					t01_step = {l9[8], hi, l9[8] ? hi : l9[7:0]};
				tmr_pkg::MODE_SPLIT:
					t01_step = {l9[8], hi, l9[7:0]};
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	wire logic w_timer01_control = sfr_wr && sfr_addr == tmr_pkg::A_T01_CONTROL;
	wire logic w_timer01_mode = sfr_wr && sfr_addr == tmr_pkg::A_T01_MODE;
	wire logic w_t0l  = sfr_wr && sfr_addr == tmr_pkg::A_T0_LOW;
	wire logic w_t1l  = sfr_wr && sfr_addr == tmr_pkg::A_T1_LOW;
	wire logic w_t0h  = sfr_wr && sfr_addr == tmr_pkg::A_T0_HIGH;
	wire logic w_t1h  = sfr_wr && sfr_addr == tmr_pkg::A_T1_HIGH;
	wire logic w_opt  = sfr_wr && sfr_addr == tmr_pkg::A_OPTION;
	wire logic w_flg  = sfr_wr && sfr_addr == tmr_pkg::A_INT_FLAGS;
	wire logic w_p3h  = sfr_wr && sfr_addr == tmr_pkg::A_P3_HI_MODE;
	wire logic w_pin  = sfr_wr && sfr_addr == tmr_pkg::A_PIN_OUT_SEL;
	wire logic w_t2c  = sfr_wr && sfr_addr == tmr_pkg::A_T2_CONTROL;
	wire logic w_rl   = sfr_wr && sfr_addr == tmr_pkg::A_T2_RLD_LOW;
	wire logic w_rh   = sfr_wr && sfr_addr == tmr_pkg::A_T2_RLD_HIGH;
	wire logic w_t2l  = sfr_wr && sfr_addr == tmr_pkg::A_T2_LOW;
	wire logic w_t2h  = sfr_wr && sfr_addr == tmr_pkg::A_T2_HIGH;
	wire logic w_aux  = sfr_wr && sfr_addr == tmr_pkg::A_AUXILIARY_CONTROL_1;

	// ------------------------------------------------------------
	// time base and edges
	// ------------------------------------------------------------
	// pins are sampled every clock, so a pulse over 2 clocks is seen
	wire logic       tick2 = unit_cnt == tmr_pkg::UNIT_LAST;
	wire logic [3:0] pin_now = {timer2_trigger_pin, timer2_count_pin,
		timer1_count_pin, timer0_count_pin};
	wire logic [3:0] pin_fall = pin_q & ~pin_now;
	wire logic slow_fall = slow_q && !slow_clock_source;
	wire logic slow16 = slow_fall && slow_div == tmr_pkg::SLOW_LAST;

	// ------------------------------------------------------------
	// timers 0 and 1
	// ------------------------------------------------------------
	wire logic [1:0] m0 = timer01_mode[tmr_pkg::B_T0_MODE +: 2];
	wire logic [1:0] m1 = timer01_mode[tmr_pkg::B_T1_MODE +: 2];
	wire logic split0 = m0 == tmr_pkg::MODE_SPLIT;
	wire logic ev0 = timer01_mode[tmr_pkg::B_T0_CT] ? pin_fall[0] : tick2;
	wire logic ev1 = !timer01_mode[tmr_pkg::B_T1_CT] ? tick2 :
		timer1_source_select ? slow16 : pin_fall[1];
	// gate lets the interrupt pin hold the count
	wire logic inc0 = timer0_run && ev0 &&
		(!timer01_mode[tmr_pkg::B_T0_GATE] || ext_irq0_pin);
	// in split mode timer 1 keeps counting for baud use, flag-less
	wire logic inc1 = (split0 || timer1_run) && ev1 &&
		m1 != tmr_pkg::MODE_SPLIT &&
		(!timer01_mode[tmr_pkg::B_T1_GATE] || ext_irq1_pin);
	wire logic [16:0] s0 = t01_step(m0, t0l, t0h, inc0);
	wire logic [16:0] s1 = t01_step(m1, t1l, t1h, inc1);
	wire logic inc0h = split0 && timer1_run && tick2;
	wire logic [8:0] h0x = {1'h0, t0h} + {8'h00, inc0h};
	wire logic ovf0 = s0[16];
	wire logic ovf1 = s1[16];
	wire logic set1 = split0 ? h0x[8] : ovf1;
	wire logic [7:0] next_t0h = split0 ? h0x[7:0] : s0[15:8];

	// ------------------------------------------------------------
	// timer 2
	// ------------------------------------------------------------
	wire logic baud = uart_rx_clock_select || uart_tx_clock_select;
	wire logic ev2 = !timer2_counter_select ? tick2 :
		timer2_source_select ? slow16 : pin_fall[2];
	wire logic inc2 = timer2_run && ev2;
	wire logic ovf2 = inc2 && t2cnt == tmr_pkg::T2_TOP;
	wire logic trig = timer2_ext_enable && pin_fall[3] && !baud;
	wire logic cap2 = trig && timer2_capture_select;
	// baud use forces reload whatever the capture select
	wire logic rel2 = ovf2 && (baud || !timer2_capture_select) ||
		trig && !timer2_capture_select;
	wire logic [15:0] next_t2 = rel2 ? t2rcap :
		t2cnt + {15'h0000, inc2};

	// ------------------------------------------------------------
	// tick counter
	// ------------------------------------------------------------
	wire logic [14:0] tick_last =
		tick_rate_select == 2'h0 ? tmr_pkg::TICK_LAST0 :
		tick_rate_select == 2'h1 ? tmr_pkg::TICK_LAST1 :
		tick_rate_select == 2'h2 ? tmr_pkg::TICK_LAST2 :
		tmr_pkg::TICK_LAST3;
	wire logic tick_hit = slow_fall && tick_cnt == tick_last;

	// ------------------------------------------------------------
	// read side
	// ------------------------------------------------------------
	logic [7:0] timer01_control_rd;
	logic [7:0] timer2_control_rd;
	logic [7:0] aux_rd;
	logic [7:0] p3h_rd;
	logic [7:0] pin_rd;
	logic [7:0] opt_rd;
	logic [7:0] flg_rd;

	always_comb
	begin
		timer01_control_rd = tmr_pkg::RST8;
		timer01_control_rd[tmr_pkg::B_T1_OVF] = timer1_overflow_flag;
		timer01_control_rd[tmr_pkg::B_T1_RUN] = timer1_run;
		timer01_control_rd[tmr_pkg::B_T0_OVF] = timer0_overflow_flag;
		timer01_control_rd[tmr_pkg::B_T0_RUN] = timer0_run;
		timer2_control_rd = tmr_pkg::RST8;
		timer2_control_rd[tmr_pkg::B_T2_OVF] = timer2_overflow_flag;
		timer2_control_rd[tmr_pkg::B_T2_EXT] = timer2_ext_event_flag;
		timer2_control_rd[tmr_pkg::B_RX_SEL] = uart_rx_clock_select;
		timer2_control_rd[tmr_pkg::B_TX_SEL] = uart_tx_clock_select;
		timer2_control_rd[tmr_pkg::B_T2_EXEN] = timer2_ext_enable;
		timer2_control_rd[tmr_pkg::B_T2_RUN] = timer2_run;
		timer2_control_rd[tmr_pkg::B_T2_CT] = timer2_counter_select;
		timer2_control_rd[tmr_pkg::B_T2_CAP] = timer2_capture_select;
		aux_rd = tmr_pkg::RST8;
		aux_rd[tmr_pkg::B_TICK_CLR] = tick_counter_clear;
		aux_rd[tmr_pkg::B_T2_SRC] = timer2_source_select;
		aux_rd[tmr_pkg::B_T1_SRC] = timer1_source_select;
		p3h_rd = tmr_pkg::RST8;
		p3h_rd[tmr_pkg::B_T0_BUZ] = timer0_buzzer_enable;
		pin_rd = tmr_pkg::RST8;
		pin_rd[tmr_pkg::B_T2_BUZ] = timer2_buzzer_enable;
		opt_rd = tmr_pkg::RST8;
		opt_rd[tmr_pkg::B_TICK_RT +: 2] = tick_rate_select;
		flg_rd = tmr_pkg::RST8;
		flg_rd[tmr_pkg::B_TICK_FLG] = tick_flag;
	end

	wire logic [7:0] rd_mux =
		sfr_addr == tmr_pkg::A_T01_CONTROL ? timer01_control_rd :
		sfr_addr == tmr_pkg::A_T01_MODE    ? timer01_mode :
		sfr_addr == tmr_pkg::A_T0_LOW      ? t0l :
		sfr_addr == tmr_pkg::A_T1_LOW      ? t1l :
		sfr_addr == tmr_pkg::A_T0_HIGH     ? t0h :
		sfr_addr == tmr_pkg::A_T1_HIGH     ? t1h :
		sfr_addr == tmr_pkg::A_OPTION      ? opt_rd :
		sfr_addr == tmr_pkg::A_INT_FLAGS   ? flg_rd :
		sfr_addr == tmr_pkg::A_P3_HI_MODE  ? p3h_rd :
		sfr_addr == tmr_pkg::A_PIN_OUT_SEL ? pin_rd :
		sfr_addr == tmr_pkg::A_T2_CONTROL  ? timer2_control_rd :
		sfr_addr == tmr_pkg::A_T2_RLD_LOW  ? t2rcap[7:0] :
		sfr_addr == tmr_pkg::A_T2_RLD_HIGH ? t2rcap[15:8] :
		sfr_addr == tmr_pkg::A_T2_LOW      ? t2cnt[7:0] :
		sfr_addr == tmr_pkg::A_T2_HIGH     ? t2cnt[15:8] :
		sfr_addr == tmr_pkg::A_AUXILIARY_CONTROL_1        ? aux_rd :
		tmr_pkg::RST8;

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			timer01_mode <= tmr_pkg::RST8;
			{timer1_run, timer0_run} <= 2'h0;
			{uart_rx_clock_select, uart_tx_clock_select} <= 2'h0;
			{timer2_ext_enable, timer2_run} <= 2'h0;
			{timer2_counter_select, timer2_capture_select} <= 2'h0;
			{timer1_source_select, timer2_source_select} <= 2'h0;
			{timer0_buzzer_enable, timer2_buzzer_enable} <= 2'h0;
			tick_rate_select <= 2'h0;
			sfr_rdata <= tmr_pkg::RST8;
		end
		else
		begin
			if (w_timer01_mode)
				timer01_mode <= sfr_wdata;
			if (w_timer01_control)
			begin
				timer1_run <= sfr_wdata[tmr_pkg::B_T1_RUN];
				timer0_run <= sfr_wdata[tmr_pkg::B_T0_RUN];
			end
			if (w_t2c)
			begin
				uart_rx_clock_select <= sfr_wdata[tmr_pkg::B_RX_SEL];
				uart_tx_clock_select <= sfr_wdata[tmr_pkg::B_TX_SEL];
				timer2_ext_enable <= sfr_wdata[tmr_pkg::B_T2_EXEN];
				timer2_run <= sfr_wdata[tmr_pkg::B_T2_RUN];
				timer2_counter_select <= sfr_wdata[tmr_pkg::B_T2_CT];
				timer2_capture_select <= sfr_wdata[tmr_pkg::B_T2_CAP];
			end
			if (w_aux)
			begin
				timer1_source_select <= sfr_wdata[tmr_pkg::B_T1_SRC];
				timer2_source_select <= sfr_wdata[tmr_pkg::B_T2_SRC];
			end
			if (w_p3h)
				timer0_buzzer_enable <= sfr_wdata[tmr_pkg::B_T0_BUZ];
			if (w_pin)
				timer2_buzzer_enable <= sfr_wdata[tmr_pkg::B_T2_BUZ];
			if (w_opt)
				tick_rate_select <= sfr_wdata[tmr_pkg::B_TICK_RT +: 2];
			if (sfr_rd)
				sfr_rdata <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// counters; a software byte write beats a count in that cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			{t0l, t0h, t1l, t1h} <= 32'h0000_0000;
			t2cnt <= tmr_pkg::RST16;
			t2rcap <= tmr_pkg::RST16;
		end
		else
		begin
			t0l <= w_t0l ? sfr_wdata : s0[7:0];
			t0h <= w_t0h ? sfr_wdata : next_t0h;
			t1l <= w_t1l ? sfr_wdata : s1[7:0];
			t1h <= w_t1h ? sfr_wdata : s1[15:8];
			t2cnt[7:0] <= w_t2l ? sfr_wdata : next_t2[7:0];
			t2cnt[15:8] <= w_t2h ? sfr_wdata : next_t2[15:8];
			t2rcap[7:0] <= w_rl ? sfr_wdata :
				cap2 ? t2cnt[7:0] : t2rcap[7:0];
			t2rcap[15:8] <= w_rh ? sfr_wdata :
				cap2 ? t2cnt[15:8] : t2rcap[15:8];
		end
	end

	// ------------------------------------------------------------
	// flags: a hardware set always wins over a clear
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			{timer0_overflow_flag, timer1_overflow_flag} <= 2'h0;
			{timer2_overflow_flag, timer2_ext_event_flag} <= 2'h0;
			{tick_flag, tick_counter_clear} <= 2'h0;
		end
		else
		begin
			timer0_overflow_flag <= ovf0 || (w_timer01_control ?
				sfr_wdata[tmr_pkg::B_T0_OVF] :
				timer0_overflow_flag && !timer0_isr_ack);
			timer1_overflow_flag <= set1 || (w_timer01_control ?
				sfr_wdata[tmr_pkg::B_T1_OVF] :
				timer1_overflow_flag && !timer1_isr_ack);
			timer2_overflow_flag <= ovf2 && !baud || (w_t2c ?
				sfr_wdata[tmr_pkg::B_T2_OVF] :
				timer2_overflow_flag);
			timer2_ext_event_flag <= trig || (w_t2c ?
				sfr_wdata[tmr_pkg::B_T2_EXT] :
				timer2_ext_event_flag);
			tick_flag <= tick_hit || tick_flag && !tick_isr_ack &&
				(!w_flg || sfr_wdata[tmr_pkg::B_TICK_FLG]);
			tick_counter_clear <= w_aux &&
				sfr_wdata[tmr_pkg::B_TICK_CLR];
		end
	end

	// ------------------------------------------------------------
	// time base, tick counter, buzzers and serial clocks
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			unit_cnt <= 1'h0;
			pin_q <= 4'hf;
			slow_q <= 1'h0;
			slow_div <= 4'h0;
			tick_cnt <= 15'h0000;
			buz0_cnt <= 5'h00;
			{wave0, wave2} <= 2'h0;
			{uart_rx_baud_tick, uart_tx_baud_tick} <= 2'h0;
		end
		else
		begin
			unit_cnt <= !unit_cnt;
			pin_q <= pin_now;
			slow_q <= slow_clock_source;
			if (slow_fall)
				slow_div <= slow_div + 4'h1;
			if (tick_counter_clear || tick_hit)
				tick_cnt <= 15'h0000;
			else if (slow_fall)
				tick_cnt <= tick_cnt + 15'h0001;
			// buzzer rate follows each timer's overflow period
			if (ovf0)
				buz0_cnt <= buz0_cnt + 5'h01;
			if (ovf0 && buz0_cnt == tmr_pkg::BUZ0_LAST)
				wave0 <= !wave0;
			if (ovf2)
				wave2 <= !wave2;
			uart_rx_baud_tick <= uart_rx_clock_select ? ovf2 : ovf1;
			uart_tx_baud_tick <= uart_tx_clock_select ? ovf2 : ovf1;
		end
	end

	assign timer0_buzzer_out = timer0_buzzer_enable && wave0;
	assign timer0_buzzer_oe  = timer0_buzzer_enable;
	assign timer2_buzzer_out = timer2_buzzer_enable && wave2;
	assign timer2_buzzer_oe  = timer2_buzzer_enable;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_unit_gap: assert property (tick2 |=> !tick2 ##1 tick2)
		else $error("count unit is not 2 clocks");
	a_t2_timer_rate: assert property (tick2 && timer2_run &&
		!timer2_counter_select && !sfr_wr && !trig && !ovf2
		|=> t2cnt == $past(t2cnt) + 16'h0001)
		else $error("timer 2 did not step on unit");
	a_t1_slow_src: assert property (timer01_mode[tmr_pkg::B_T1_CT] &&
		timer1_source_select && !slow16 && !split0 && !w_t1l && !w_t1h
		|=> $stable({t1h, t1l}))
		else $error("timer 1 moved without slow tick");
	a_t2_slow_src: assert property (timer2_counter_select &&
		timer2_source_select && !slow16 && !trig && !w_t2l && !w_t2h
		|=> $stable(t2cnt))
		else $error("timer 2 moved without slow tick");
	a_buz0_toggle: assert property (ovf0 &&
		buz0_cnt == tmr_pkg::BUZ0_LAST |=> wave0 != $past(wave0))
		else $error("buzzer 0 missed its toggle");
	a_buz2_toggle: assert property (ovf2 && timer2_buzzer_enable
		&& !w_pin |=> timer2_buzzer_out != $past(timer2_buzzer_out))
		else $error("buzzer 2 missed its toggle");
	a_ext_flag: assert property (trig |=> timer2_ext_event_flag)
		else $error("trigger edge left event flag clear");
	a_t2_reload: assert property (rel2 && !w_t2l && !w_t2h
		|=> t2cnt == $past(t2rcap))
		else $error("timer 2 reload value wrong");
	a_baud_no_flag: assert property (baud && !w_t2c &&
		!timer2_overflow_flag |=> !timer2_overflow_flag)
		else $error("overflow flag set in baud use");
	a_tick_wrap: assert property (tick_hit && !tick_counter_clear
		|=> tick_flag && tick_cnt == 15'h0000)
		else $error("tick interval end mishandled");
	a_flag_keep: assert property (w_flg && tick_flag &&
		sfr_wdata[tmr_pkg::B_TICK_FLG] && !tick_isr_ack |=> tick_flag)
		else $error("writing one cleared tick flag");
	a_clr_auto: assert property (tick_counter_clear && !w_aux
		|=> !tick_counter_clear && tick_cnt == 15'h0000)
		else $error("tick clear did not act once");
	a_gate_hold: assert property (m0 == tmr_pkg::MODE_16BIT &&
		timer01_mode[tmr_pkg::B_T0_GATE] && !ext_irq0_pin && !w_t0l && !w_t0h
		|=> $stable({t0h, t0l}))
		else $error("gated timer 0 counted");
	a_ack_clear: assert property (timer0_isr_ack && !ovf0 &&
		!w_timer01_control |=> !timer0_overflow_flag)
		else $error("service entry left flag set");

	c_t2_reload: cover property (ovf2 && !timer2_capture_select);
	c_t2_capture: cover property (cap2);
	c_tick_hit: cover property (tick_hit);
	c_buz0_wave: cover property (ovf0 && buz0_cnt == tmr_pkg::BUZ0_LAST);

endmodule
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the timer block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic       clk = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0;
	logic [1:0] irq = 2'h3;
	logic [2:0] ack = 3'h0;
	logic       trig_go = 1'h0, trig, slow;
	logic [4:0] flg;
	logic [3:0] buz;
	logic [1:0] bd;
	logic [7:0] rg [12] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
		8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h80};
	int         num_errors = 0, checks_done = 0, lo, hi, v, c;
	always #50 clk = ~clk;
	tmr_pins tmr_pins_i (.clk(clk), .trig_go(trig_go),
		.trigger_pin(trig), .slow_clk(slow));
	tmr_timers tmr_timers_i (.clk(clk), .srst(srst), .sfr_addr(addr),
		.sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
		.timer0_count_pin(1'h1), .timer1_count_pin(1'h1),
		.timer2_count_pin(1'h1), .timer2_trigger_pin(trig),
		.ext_irq0_pin(irq[0]), .ext_irq1_pin(irq[1]),
		.slow_clock_source(slow), .timer0_isr_ack(ack[0]),
		.timer1_isr_ack(ack[1]), .tick_isr_ack(ack[2]),
		.timer0_overflow_flag(flg[0]), .timer1_overflow_flag(flg[1]),
		.timer2_overflow_flag(flg[2]), .timer2_ext_event_flag(flg[3]),
		.tick_flag(flg[4]), .timer0_buzzer_out(buz[0]),
		.timer0_buzzer_oe(buz[1]), .timer2_buzzer_out(buz[2]),
		.timer2_buzzer_oe(buz[3]), .uart_rx_baud_tick(bd[0]),
		.uart_tx_baud_tick(bd[1]));
	task automatic check(input logic [15:0] seen, input logic [15:0] e);
		checks_done++;
		if (seen !== e)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		@(posedge clk);
		check(rdata, e);
	endtask
	// counts n units; mode 0 13-bit, 1 wraps to r, 2 reloads low from high
	function automatic int model(int m, int v, int r, int n);
		repeat (n)
			if (m == 0)
				v = ((v & 31) == 31) ? (v + 225) % 65536 : v + 1;
			else if (m == 2)
				v = ((v & 255) == 255) ? (v & 'hff00) | (v >> 8) : v + 1;
			else
				v = (v == 65535) ? r : v + 1;
		return v;
	endfunction
	task automatic test_done;
		if (num_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#1_000_000;
		num_errors++;
		test_done;
	end
	initial
	begin
		v = $urandom(78476);
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		foreach (rg[i])
			rd_chk(rg[i], 0);
		foreach (rg[i])
			if (i > 1 && i != 6)
			begin
				v = $urandom % 256;
				wr_reg(rg[i], v);
				rd_chk(rg[i], (i == 11) ? 0 : v);
			end
		// mode 3 of the loop is 16-bit with the gate pin held low
		for (int t = 0; t < 2; t++)
			for (int m = 0; m < 4; m++)
			begin
				lo = (m == 0) ? $urandom % 32 : 8'ha0 | $urandom % 32;
				hi = (m == 2) ? $urandom % 256 : 8'hff;
				irq <= (m == 3) ? 2'h0 : 2'h3;
				wr_reg(8'h89, (m % 3 + m / 3 * 9) << 4 * t);
				wr_reg(8'h8a + t, lo);
				wr_reg(8'h8c + t, hi);
				wr_reg(8'h88, 8'h10 << 2 * t);
				repeat (198) @(posedge clk);
				check(flg[t], m < 3);
				wr_reg(8'h88, 8'h20 << 2 * t);
				v = model(m % 3, hi << 8 | lo, 0, (m < 3) ? 100 : 0);
				rd_chk(8'h8a + t, v % 256);
				rd_chk(8'h8c + t, v / 256);
				ack[t] <= 1'h1;
				@(posedge clk);
				ack[t] <= 1'h0;
				@(posedge clk);
				check(flg[t], 0);
			end
		v = $urandom % 65536;
		lo = 8'ha0 | $urandom % 32;
		wr_reg(8'hca, v % 256);
		wr_reg(8'hcb, v / 256);
		wr_reg(8'hcc, lo);
		wr_reg(8'hcd, 8'hff);
		wr_reg(8'hc8, 8'h04);
		repeat (198) @(posedge clk);
		check(flg[2], 1);
		wr_reg(8'hc8, 8'h80);
		c = model(1, 'hff00 | lo, v, 100);
		rd_chk(8'hcc, c % 256);
		rd_chk(8'hcd, c / 256);
		wr_reg(8'hc8, 8'h08);
		trig_go <= 1'h1;
		repeat (8) @(posedge clk);
		trig_go <= 1'h0;
		check(flg[3], 1);
		rd_chk(8'hcc, v % 256);
		rd_chk(8'hcd, v / 256);
		wr_reg(8'h94, 8'h03);
		wr_reg(8'hf8, 8'h40);
		c = 0;
		while (flg[4] !== 1'h1 && c < 1100)
		begin
			@(posedge clk);
			c++;
		end
		check(c > 1000 && c < 1050, 1);
		rd_chk(8'hf8, 0);
		wr_reg(8'h95, 8'hff);
		check(flg[4], 1);
		wr_reg(8'h95, 8'hfe);
		check(flg[4], 0);
		// baud use: timer 2 overflow feeds both serial clocks, no flag
		wr_reg(8'ha5, 8'h80);
		check(buz[1], 1);
		wr_reg(8'ha6, 8'h04);
		check(buz[3], 1);
		wr_reg(8'hcc, 8'hff);
		wr_reg(8'hcd, 8'hff);
		lo = buz[2];
		wr_reg(8'hc8, 8'h34);
		c = 0;
		while (bd !== 2'h3 && c < 8)
		begin
			@(posedge clk);
			c++;
		end
		check(c < 8, 1);
		check(buz[2], !lo);
		check(flg[2], 0);
		test_done;
	end
endmodule
`default_nettype wire

// file: sim/tmr_pins.sv
// pin-side model: trigger source and free-running slow clock
`timescale 1ns/10ps
`default_nettype none
module tmr_pins (
	// clock and request
	input  wire logic trig_go,
	input  wire logic clk,
	// pins
	output logic      trigger_pin,
	output logic      slow_clk
);
	initial slow_clk = 1'h0;
	initial trigger_pin = 1'h1;
	// crystal runs free, 8 system clocks a cycle
	always @(posedge clk)
	begin
		repeat (3) @(posedge clk);
		slow_clk <= ~slow_clk;
	end
	// pulled-up line, low for 4 clocks, well over 2
	always @(posedge trig_go)
	begin
		@(posedge clk);
		trigger_pin <= 1'h0;
		repeat (4) @(posedge clk);
		trigger_pin <= 1'h1;
	end
endmodule
`default_nettype wire
